// ### vms_pkg.sv
// Purpose: shared constants and types for the variable-memory save block
// Assumes: 40 MHz clock, byte-wide memories with combinational read
// Notes:   register indices and command bit positions live here; status bit positions are set in the save block
package vms_pkg;

  localparam int unsigned CLK_KHZ      = 40000;
  localparam int unsigned SAVE_TIME_MS = 15;
  // least save time, so the count must not round down: whole ms times whole kHz is exact
  localparam int unsigned SAVE_CYC     = SAVE_TIME_MS * CLK_KHZ;
  localparam int unsigned PU_SYNC_CYC  = 3;

  localparam int unsigned DEF_VM_BASE   = 256;
  localparam int unsigned DEF_PERM_SIZE = 256;
  localparam int unsigned DEF_IMG_SIZE  = 512;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SRC  = 4'h1;
  localparam logic [3:0] REG_STAT = 4'h2;
  localparam logic [3:0] REG_CART = 4'h3;

  localparam int unsigned CTRL_REQ_BIT   = 7;
  localparam int unsigned CART_START_BIT = 0;
  localparam int unsigned CART_CLR_BIT   = 1;

  localparam logic [1:0] SZ_WORD  = 2'h2;
  localparam logic [1:0] SZ_DWORD = 2'h3;

  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] SRC_RST    = 16'h0000;
  localparam logic [7:0]  BLANK_BYTE = 8'hFF;
  // arbitrary value
  localparam logic [7:0]  DEF_MODEL_ID = 8'h5A;
  localparam logic [15:0] CART_HDR_ADDR = 16'h0000;
  localparam logic [15:0] CART_IMG_ADDR = 16'h0001;

  typedef enum logic [2:0] {
    ST_PU_SYNC, ST_PU_HDR, ST_RD, ST_WR, ST_SV_WAIT, ST_CC_HDR, ST_IDLE
  } vms_state_t;

  typedef enum logic [2:0] {
    JB_CLR, JB_C2R, JB_R2E, JB_SAVE, JB_CC
  } vms_job_t;

endpackage : vms_pkg

// ### vms_sync2.sv
// Purpose: two-flop synchroniser for a level from a pin
// Assumes: level changes slowly compared with the clock
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
module vms_sync2
  import vms_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic pinIn,
  output logic      levelOut
);

  logic meta_q;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      meta_q   <= 1'b0;
      levelOut <= 1'b0;
    end
    else
    begin
      meta_q   <= pinIn;
      levelOut <= meta_q;
    end
  end

endmodule : vms_sync2

// ### vms_timer.sv
// Purpose: one-shot down counter that pulses done after a loaded count
// Assumes: start is a one-cycle pulse, load is at least one
// Notes:   a new start while running reloads the count
`timescale 1ns/1ps
module vms_timer
  import vms_pkg::*;
#(
  parameter int unsigned W = 20
)(
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              done
);

  logic [W-1:0] count_q;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      count_q <= '0;
      done    <= 1'b0;
    end
    else
    begin
      done <= (count_q == W'(1)) && !start;
      if (start)
        count_q <= load;
      else if (count_q != '0)
        count_q <= count_q - W'(1);
    end
  end

endmodule : vms_timer

// ### vms_eeprom_save.sv
// Purpose: save of variable memory to EEPROM, cartridge copy and restore
// Assumes: RAM and cartridge are byte ports with combinational read, EEPROM is a write-only byte port
// Notes:   scanEnd comes from the scan engine on this clock
// What this block does
// [R1] store byte, word or dword into permanent area
// [R2] program loads source offset from base first
// [R3] size field: 00/01 byte, 10 word, 11 dword
// [R4] program sets request bit only after setup
// [R5] sample request bit at every scan end; only sampled in idle, not during a cartridge copy
// [R6] clear request bit when each save ends
// [R7] program keeps source unchanged until cleared
// [R8] each save overwrites previous target value
// [R9] save never touches the memory cartridge
// [R10] save lengthens the scan by 15-20 ms
// [R11] program saves only on infrequent events
// [R12] cartridge copy only with cartridge present
// [R13] power-up: clear RAM, cartridge to RAM, to EEPROM
// [R14] blank or foreign cartridge flags an error
// [R15] new request waits until current one clears
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module vms_eeprom_save
  import vms_pkg::*;
#(
  parameter int unsigned VM_BASE     = DEF_VM_BASE,
  parameter int unsigned PERM_SIZE   = DEF_PERM_SIZE,
  parameter int unsigned IMG_SIZE    = DEF_IMG_SIZE,
  parameter int unsigned SAVE_CYCLES = SAVE_CYC,
  parameter logic [7:0]  MODEL_ID    = DEF_MODEL_ID
)(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic [3:0]        regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic              scanEnd,
  output logic                   scanHold,
  input  wire logic              cartPresentPin,
  output logic      [ADDR_W-1:0] ramAddr,
  output logic                   ramWe,
  output logic      [7:0]        ramWdata,
  input  wire logic [7:0]        ramRdata,
  output logic      [ADDR_W-1:0] eeAddr,
  output logic                   eeWe,
  output logic      [7:0]        eeWdata,
  output logic      [ADDR_W-1:0] cartAddr,
  output logic                   cartWe,
  output logic      [7:0]        cartWdata,
  input  wire logic [7:0]        cartRdata
);

  localparam int unsigned TW = $clog2(SAVE_CYCLES + 1);

  vms_state_t        state_q, state_d;
  vms_job_t          job_q, job_d;
  logic [ADDR_W-1:0] idx_q, idx_d, len_q, len_d;
  logic [ADDR_W-1:0] srcBase_q, srcBase_d, dstBase_q, dstBase_d;
  logic [ADDR_W-1:0] ramAddr_d, eeAddr_d, cartAddr_d;
  logic              ramWe_d, eeWe_d, cartWe_d;
  logic [7:0]        ramWdata_d, eeWdata_d, cartWdata_d;
  logic              ctrlReq_q, pend_q, cartStart_q, cartErr_q, rangeErr_q;
  logic [1:0]        ctrlSize_q;
  logic [15:0]       srcOff_q;
  logic              cartPres, timerDone, timerStart;
  logic              saveDone, cartErrSet, rangeErrSet, ccTaken, scanHold_d;

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic              wrCtrl, wrSrc, wrCart, saveBusy, ccBusy, puBusy;
  logic              lastByte, saveFits, dstRam, dstEe, dstCart;
  logic [2:0]        saveLen;
  logic [ADDR_W:0]   saveEnd;
  logic [ADDR_W-1:0] rdAddr, wrAddr, vmAddr;
  logic [7:0]        srcByte;
  logic [DATA_W-1:0] statWord, rdMux;

  assign wrCtrl   = regWr && (regAddr == REG_CTRL);
  assign wrSrc    = regWr && (regAddr == REG_SRC);
  assign wrCart   = regWr && (regAddr == REG_CART);
  assign saveBusy = (state_q != ST_IDLE) && (job_q == JB_SAVE);
  assign ccBusy   = (state_q != ST_IDLE) && (job_q == JB_CC);
  assign puBusy   = (state_q != ST_IDLE) && !saveBusy && !ccBusy;
  assign saveLen  = (ctrlSize_q == SZ_DWORD) ? 3'h4 :
                    (ctrlSize_q == SZ_WORD)  ? 3'h2 : 3'h1;  // [R3]
  assign saveEnd  = {1'b0, srcOff_q} + {{(ADDR_W-2){1'b0}}, saveLen};
  assign saveFits = saveEnd <= (ADDR_W+1)'(PERM_SIZE);
  assign vmAddr   = ADDR_W'(VM_BASE) + srcOff_q;  // [R2]
  assign rdAddr   = srcBase_q + idx_q;
  assign wrAddr   = dstBase_q + idx_q;
  assign lastByte = idx_q == (len_q - ADDR_W'(1));
  assign dstRam   = (job_q == JB_CLR) || (job_q == JB_C2R);
  assign dstEe    = (job_q == JB_R2E) || (job_q == JB_SAVE);
  assign dstCart  = job_q == JB_CC;
  assign srcByte  = (job_q == JB_CLR) ? 8'h00 :
                    (job_q == JB_C2R) ? cartRdata : ramRdata;
  assign statWord = {9'h000, rangeErr_q, cartErr_q, puBusy, ccBusy,
                     cartPres, pend_q, saveBusy};
  assign rdMux    = (regAddr == REG_CTRL) ?
                      {8'h00, ctrlReq_q, 5'h00, ctrlSize_q} :
                    (regAddr == REG_SRC)  ? srcOff_q :
                    (regAddr == REG_STAT) ? statWord : 16'h0000;
  assign scanHold_d = (state_d != ST_IDLE) && (job_d != JB_CC);  // [R10]

  vms_sync2 uSync (
    .clock    (clock),
    .srst     (srst),
    .pinIn    (cartPresentPin),
    .levelOut (cartPres)
  );

  // write time of the array is only known as a least figure
  vms_timer #(.W(TW)) uTimer (
    .clock (clock),
    .srst  (srst),
    .start (timerStart),
    .load  (TW'(SAVE_CYCLES)),
    .done  (timerDone)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer: every job writes len bytes to dst, copied from src, or zeros for the clear job

  always_comb
  begin
    state_d     = state_q;
    job_d       = job_q;
    idx_d       = idx_q;
    len_d       = len_q;
    srcBase_d   = srcBase_q;
    dstBase_d   = dstBase_q;
    ramAddr_d   = ramAddr;
    eeAddr_d    = eeAddr;
    cartAddr_d  = cartAddr;
    ramWdata_d  = ramWdata;
    eeWdata_d   = eeWdata;
    cartWdata_d = cartWdata;
    ramWe_d     = 1'b0;
    eeWe_d      = 1'b0;
    cartWe_d    = 1'b0;
    timerStart  = 1'b0;
    saveDone    = 1'b0;
    cartErrSet  = 1'b0;
    rangeErrSet = 1'b0;
    ccTaken     = 1'b0;
    unique case (state_q)
      ST_PU_SYNC:
      begin
        // wait until the synchronised presence level is valid
        idx_d = idx_q + ADDR_W'(1);
        if (idx_q == ADDR_W'(PU_SYNC_CYC))
        begin
          idx_d      = '0;
          cartAddr_d = CART_HDR_ADDR;
          state_d    = cartPres ? ST_PU_HDR : ST_IDLE;
        end
      end
      ST_PU_HDR:
      begin
        if ((cartRdata == BLANK_BYTE) || (cartRdata != MODEL_ID))
        begin
          cartErrSet = 1'b1;  // [R14]
          state_d    = ST_IDLE;
        end
        else
        begin
          job_d     = JB_CLR;  // [R13]
          srcBase_d = '0;
          dstBase_d = '0;
          len_d     = ADDR_W'(IMG_SIZE);
          state_d   = ST_RD;
        end
      end
      ST_RD:
      begin
        state_d = ST_WR;
        if (job_q == JB_C2R)
          cartAddr_d = rdAddr;
        else
          ramAddr_d = rdAddr;
        if ((job_q == JB_CC) && !cartPres)
        begin
          cartErrSet = 1'b1;  // [R12]
          state_d    = ST_IDLE;
        end
      end
      ST_WR:
      begin
        idx_d   = idx_q + ADDR_W'(1);
        state_d = ST_RD;
        if (dstRam)
        begin
          ramAddr_d  = wrAddr;
          ramWe_d    = 1'b1;
          ramWdata_d = srcByte;
        end
        if (dstEe)
        begin
          eeAddr_d  = wrAddr;  // [R8]
          eeWe_d    = 1'b1;  // [R1]
          eeWdata_d = srcByte;
        end
        if (dstCart)
        begin
          cartAddr_d  = wrAddr;
          cartWe_d    = cartPres;  // [R12]
          cartWdata_d = srcByte;
        end
        if (lastByte)
        begin
          idx_d = '0;
          unique case (job_q)
            JB_CLR:
            begin
              job_d     = JB_C2R;  // [R13]
              srcBase_d = CART_IMG_ADDR;
            end
            JB_C2R:
            begin
              job_d     = JB_R2E;  // [R13]
              srcBase_d = '0;
            end
            JB_R2E:  state_d = ST_IDLE;
            JB_SAVE:
            begin
              state_d    = ST_SV_WAIT;
              timerStart = 1'b1;  // [R10]
            end
            JB_CC:   state_d = ST_CC_HDR;
          endcase
        end
      end
      ST_SV_WAIT:
      begin
        if (timerDone)
        begin
          saveDone = 1'b1;  // [R6]
          state_d  = ST_IDLE;
        end
      end
      ST_CC_HDR:
      begin
        // header goes last so a torn copy onto a blank cartridge reads back as blank
        cartAddr_d  = CART_HDR_ADDR;
        cartWe_d    = cartPres;
        cartWdata_d = MODEL_ID;
        cartErrSet  = !cartPres;
        state_d     = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (scanEnd && ctrlReq_q)  // [R5]
        begin
          if (saveFits)
          begin
            job_d     = JB_SAVE;
            srcBase_d = vmAddr;
            dstBase_d = vmAddr;  // [R8]
            len_d     = {{(ADDR_W-3){1'b0}}, saveLen};
            state_d   = ST_RD;
          end
          else
          begin
            rangeErrSet = 1'b1;
            saveDone    = 1'b1;  // [R6]
          end
        end
        else if (cartStart_q)
        begin
          ccTaken = 1'b1;
          if (cartPres)
          begin
            job_d     = JB_CC;  // [R12]
            srcBase_d = '0;
            dstBase_d = CART_IMG_ADDR;
            len_d     = ADDR_W'(IMG_SIZE);
            state_d   = ST_RD;
          end
          else
            cartErrSet = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q   <= ST_PU_SYNC;
      job_q     <= JB_CLR;
      idx_q     <= '0;
      len_q     <= '0;
      srcBase_q <= '0;
      dstBase_q <= '0;
      scanHold  <= 1'b1;
    end
    else
    begin
      state_q   <= state_d;
      job_q     <= job_d;
      idx_q     <= idx_d;
      len_q     <= len_d;
      srcBase_q <= srcBase_d;
      dstBase_q <= dstBase_d;
      scanHold  <= scanHold_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      {ramAddr, eeAddr, cartAddr}    <= '0;
      {ramWe, eeWe, cartWe}          <= '0;
      {ramWdata, eeWdata, cartWdata} <= '0;
    end
    else
    begin
      {ramAddr, eeAddr, cartAddr}    <= {ramAddr_d, eeAddr_d, cartAddr_d};
      {ramWe, eeWe, cartWe}          <= {ramWe_d, eeWe_d, cartWe_d};
      {ramWdata, eeWdata, cartWdata} <= {ramWdata_d, eeWdata_d, cartWdata_d};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrlReq_q   <= CTRL_RST[CTRL_REQ_BIT];
      ctrlSize_q  <= CTRL_RST[1:0];
      srcOff_q    <= SRC_RST;
      pend_q      <= 1'b0;
      cartStart_q <= 1'b0;
      cartErr_q   <= 1'b0;
      rangeErr_q  <= 1'b0;
      regRdata    <= '0;
    end
    else
    begin
      regRdata <= regRd ? rdMux : 16'h0000;
      if (wrCtrl)
        ctrlSize_q <= regWdata[1:0];
      if (wrSrc)
        srcOff_q <= regWdata;
      // a write beside a range-error clear wins, one during a save only sets pend_q; promotion waits for the clear
      if (wrCtrl && !saveBusy)
        ctrlReq_q <= regWdata[CTRL_REQ_BIT];
      else if (saveDone)
        ctrlReq_q <= 1'b0;  // [R6]
      else if (pend_q && !saveBusy)
        ctrlReq_q <= 1'b1;  // [R15]
      if (wrCtrl && regWdata[CTRL_REQ_BIT] && saveBusy)
        pend_q <= 1'b1;  // [R15]
      else if (!saveBusy)
        pend_q <= 1'b0;
      if (wrCart && regWdata[CART_START_BIT])
        cartStart_q <= 1'b1;
      else if (ccTaken)
        cartStart_q <= 1'b0;
      if (cartErrSet)
        cartErr_q <= 1'b1;
      else if (wrCart && regWdata[CART_CLR_BIT])
        cartErr_q <= 1'b0;
      if (rangeErrSet)
        rangeErr_q <= 1'b1;
      else if (wrCart && regWdata[CART_CLR_BIT])
        rangeErr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sample_at_end_a: assert property (  // [R5]
    (state_q == ST_IDLE) && scanEnd && ctrlReq_q && saveFits
    |=> (state_q == ST_RD) && (job_q == JB_SAVE))
    else $error("request not taken at scan end");

  size_map_a: assert property (  // [R3]
    (state_q == ST_IDLE) && scanEnd && ctrlReq_q && saveFits
    |=> len_q == (($past(ctrlSize_q) == SZ_DWORD) ? 16'h0004 :
                  ($past(ctrlSize_q) == SZ_WORD) ? 16'h0002 : 16'h0001))
    else $error("save length does not match size field");

  ee_data_a: assert property (  // [R1]
    eeWe && (job_q == JB_SAVE) |-> eeWdata == $past(ramRdata))
    else $error("saved byte differs from source");

  ee_target_a: assert property (  // [R8]
    eeWe && (job_q == JB_SAVE)
    |-> (eeAddr >= 16'(VM_BASE)) && (eeAddr < 16'(VM_BASE + PERM_SIZE)))
    else $error("save outside permanent area");

  req_clear_a: assert property (  // [R6]
    (state_q == ST_SV_WAIT) && timerDone |=> !ctrlReq_q && (state_q == ST_IDLE))
    else $error("request bit not cleared at save end");

  no_cart_a: assert property (  // [R9]
    saveBusy |-> !cartWe)
    else $error("cartridge written during save");

  hold_scan_a: assert property (  // [R10]
    (state_q == ST_SV_WAIT) |-> scanHold && saveBusy)
    else $error("scan not held during save");

  cart_gate_a: assert property (  // [R12]
    cartWe |-> $past(cartPres))
    else $error("cartridge written while absent");

  pu_order_a: assert property (  // [R13]
    (state_q == ST_WR) && lastByte && (job_q == JB_CLR)
    |=> (job_q == JB_C2R) && (state_q == ST_RD) && (idx_q == 16'h0000))
    else $error("restore order broken");

  pu_err_a: assert property (  // [R14]
    (state_q == ST_PU_HDR) && (cartRdata != MODEL_ID) |=> cartErr_q)
    else $error("bad cartridge not flagged");

  pend_hold_a: assert property (  // [R15]
    wrCtrl && regWdata[CTRL_REQ_BIT] && saveBusy |=> pend_q && !(state_q == ST_RD && idx_q == '0))
    else $error("request during save not held back");

  save_done_c: cover property (
    (state_q == ST_SV_WAIT) && timerDone ##1 pend_q ##1 ctrlReq_q);
  cart_copy_c: cover property ((state_q == ST_CC_HDR) && cartPres);
  pu_restore_c: cover property ((job_q == JB_R2E) && (state_q == ST_WR) && lastByte);

endmodule : vms_eeprom_save

// ### vms_mem_model.sv
// Purpose: RAM, EEPROM and cartridge byte stores facing the save block
// Assumes: combinational read, write on the rising edge
// Notes:   absent cartridge reads a changing pattern, not stale data
`timescale 1ns/1ps
module vms_mem_model
  import vms_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              cartPresent,
  input  wire logic [ADDR_W-1:0] ramAddr,
  input  wire logic              ramWe,
  input  wire logic [7:0]        ramWdata,
  output logic      [7:0]        ramRdata,
  input  wire logic [ADDR_W-1:0] eeAddr,
  input  wire logic              eeWe,
  input  wire logic [7:0]        eeWdata,
  input  wire logic [ADDR_W-1:0] cartAddr,
  input  wire logic              cartWe,
  input  wire logic [7:0]        cartWdata,
  output logic      [7:0]        cartRdata
);
  logic [7:0] ram [64];
  logic [7:0] ee [64];
  logic [7:0] cart [64];
  logic [7:0] cartLast_q = 8'h00;
  int         cartWrites = 0;
  ////////////////////////////////////////////////////////////////////////////
  assign ramRdata  = ram[ramAddr[5:0]];
  // a pulled cartridge must not look like it still holds its last byte
  assign cartRdata = cartPresent ? cart[cartAddr[5:0]] : ~cartLast_q;
  always @(posedge clock)
  begin
    if (ramWe) ram[ramAddr[5:0]] <= ramWdata;
    if (eeWe) ee[eeAddr[5:0]] <= eeWdata;
    if (cartWe) cartWrites <= cartWrites + 1;
    if (cartWe && cartPresent) cart[cartAddr[5:0]] <= cartWdata;
    cartLast_q <= cartRdata;
  end
endmodule : vms_mem_model

// ### vms_eeprom_save_test.sv
// Purpose: self-checking bench for the variable-memory save block
// Assumes: shortened save time, small image and permanent area
// Notes:   memories preloaded and inspected directly in the model
`timescale 1ns/1ps
module vms_eeprom_save_test;
  import vms_pkg::*;
  localparam int unsigned SV_CYC = 30;
  localparam int unsigned VB = 8;
  logic clock = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, scanEnd = 1'b0;
  logic cartPresentPin = 1'b0, scanHold, ramWe, eeWe, cartWe;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000, regRdata, ramAddr, eeAddr, cartAddr, rd;
  logic [7:0] ramWdata, ramRdata, eeWdata, cartWdata, cartRdata, b;
  int err_count = 0, checked = 0, holdRun = 0, lastHold = 0, i, s, n, cw;
  ////////////////////////////////////////////////////////////////////////////
  vms_eeprom_save #(.VM_BASE(VB), .PERM_SIZE(8), .IMG_SIZE(16), .SAVE_CYCLES(SV_CYC),
    .MODEL_ID(DEF_MODEL_ID)) u_dut (.clock(clock), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .scanEnd(scanEnd), .scanHold(scanHold), .cartPresentPin(cartPresentPin),
    .ramAddr(ramAddr), .ramWe(ramWe), .ramWdata(ramWdata), .ramRdata(ramRdata),
    .eeAddr(eeAddr), .eeWe(eeWe), .eeWdata(eeWdata), .cartAddr(cartAddr),
    .cartWe(cartWe), .cartWdata(cartWdata), .cartRdata(cartRdata));
  vms_mem_model u_mem (.clock(clock), .cartPresent(cartPresentPin), .ramAddr(ramAddr),
    .ramWe(ramWe), .ramWdata(ramWdata), .ramRdata(ramRdata), .eeAddr(eeAddr),
    .eeWe(eeWe), .eeWdata(eeWdata), .cartAddr(cartAddr), .cartWe(cartWe),
    .cartWdata(cartWdata), .cartRdata(cartRdata));
  always #12.5 clock = ~clock;
  // length of the last scan hold, to see how long a save stalls the scan
  always @(posedge clock)
  begin
    if (scanHold === 1'b1) holdRun++;
    else
    begin
      if (holdRun > 0) lastHold = holdRun;
      holdRun = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("counts: checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : regWrite
  task automatic regRead(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : regRead
  task automatic pulseScan();
    @(posedge clock);
    scanEnd <= 1'b1;
    @(posedge clock);
    scanEnd <= 1'b0;
  endtask : pulseScan
  // poll a register bit; a bit that never settles ends the run
  task automatic waitBit(input logic [3:0] a, input int bi, input logic v);
    logic [15:0] d;
    int k;
    for (k = 0; k < 300; k++)
    begin
      regRead(a, d);
      if (d[bi] === v) break;
    end
    if (k == 300)
    begin
      err_count++;
      $display("MISMATCH wait reg %0d bit %0d expected %0b seen %0b", a, bi, v, d[bi]);
      wrap_up();
    end
  endtask : waitBit
  task automatic doReset();
    int k;
    @(posedge clock);
    srst <= 1'b1;
    repeat (11) @(posedge clock);
    srst <= 1'b0;
    for (k = 0; k < 3000; k++)
    begin
      @(posedge clock);
      if (scanHold === 1'b0) break;
    end
    if (k == 3000)
    begin
      err_count++;
      $display("MISMATCH scanHold expected 0 seen %b", scanHold);
      wrap_up();
    end
    // the last restore write lands one edge after the hold drops
    @(posedge clock);
  endtask : doReset
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (i = 0; i < 64; i++)
    begin
      u_mem.ram[i] = 8'h00;
      u_mem.ee[i] = 8'h00;
      u_mem.cart[i] = 8'hFF;
    end
    doReset();
    regRead(REG_CTRL, rd); cmp("ctrl reset", 16'h0000, rd);
    regRead(REG_SRC, rd); cmp("src reset", 16'h0000, rd);
    regRead(REG_STAT, rd); cmp("status reset", 16'h0000, rd);
    regRead(REG_CART, rd); cmp("cart cmd read", 16'h0000, rd);
    regRead(4'h9, rd); cmp("unmapped", 16'h0000, rd);
    regWrite(REG_SRC, 16'h1234); regRead(REG_SRC, rd); cmp("src rw", 16'h1234, rd);
    regWrite(REG_CTRL, 16'h007F); regRead(REG_CTRL, rd); cmp("ctrl bits", 16'h0003, rd);
    $display("test registers done");
    for (s = 0; s < 4; s++)
    begin
      n = (s == 2) ? 2 : (s == 3) ? 4 : 1;
      for (i = 0; i < 5; i++)
      begin
        u_mem.ram[VB + s + i] = 8'h41 + 8'(16 * s + i);
        u_mem.ee[VB + s + i] = 8'hEE;
      end
      regWrite(REG_SRC, 16'(s));
      regWrite(REG_CTRL, 16'(s));
      regWrite(REG_CTRL, 16'h0080 | 16'(s));
      repeat (10) @(posedge clock);
      regRead(REG_CTRL, rd); cmp("req held", 16'h0080 | 16'(s), rd);
      cmp("no early write", 16'h00EE, {8'h00, u_mem.ee[VB + s]});
      pulseScan();
      waitBit(REG_CTRL, 7, 1'b0);
      for (i = 0; i < 5; i++)
      begin
        b = (i < n) ? 8'h41 + 8'(16 * s + i) : 8'hEE;
        cmp("ee byte", {8'h00, b}, {8'h00, u_mem.ee[VB + s + i]});
      end
      cmp("hold length", 16'h0001,
          16'((lastHold >= SV_CYC) && (lastHold <= SV_CYC + 16)));
    end
    $display("test sizes done");
    u_mem.ram[VB] = 8'h11;
    regWrite(REG_SRC, 16'h0000);
    regWrite(REG_CTRL, 16'h0000);
    regWrite(REG_CTRL, 16'h0080);
    pulseScan();
    repeat (4) @(posedge clock);
    regWrite(REG_CTRL, 16'h0080);
    regRead(REG_STAT, rd); cmp("busy pending", 16'h0003, rd);
    waitBit(REG_STAT, 0, 1'b0);
    cmp("first save", 16'h0011, {8'h00, u_mem.ee[VB]});
    regRead(REG_CTRL, rd); cmp("pending promoted", 16'h0080, rd);
    u_mem.ram[VB] = 8'h22;
    pulseScan();
    waitBit(REG_CTRL, 7, 1'b0);
    cmp("second save", 16'h0022, {8'h00, u_mem.ee[VB]});
    $display("test pending done");
    regWrite(REG_SRC, 16'h0007);
    regWrite(REG_CTRL, 16'h0002);
    regWrite(REG_CTRL, 16'h0082);
    pulseScan();
    repeat (3) @(posedge clock);
    regRead(REG_CTRL, rd); cmp("range clear", 16'h0002, rd);
    regRead(REG_STAT, rd); cmp("range err", 16'h0040, rd);
    regWrite(REG_CART, 16'h0002);
    regRead(REG_STAT, rd); cmp("err cleared", 16'h0000, rd);
    $display("test range done");
    cw = u_mem.cartWrites;
    regWrite(REG_CART, 16'h0001);
    repeat (4) @(posedge clock);
    regRead(REG_STAT, rd); cmp("absent copy err", 16'h0020, rd);
    cmp("absent no write", 16'(cw), 16'(u_mem.cartWrites));
    regWrite(REG_CART, 16'h0002);
    cartPresentPin <= 1'b1;
    for (i = 0; i < 16; i++) u_mem.ram[i] = 8'hC0 + 8'(i);
    repeat (4) @(posedge clock);
    regRead(REG_STAT, rd); cmp("present", 16'h0004, rd);
    regWrite(REG_CART, 16'h0001);
    repeat (3) @(posedge clock);
    waitBit(REG_STAT, 3, 1'b0);
    for (i = 0; i < 16; i++)
      cmp("cart image", 16'h00C0 + 16'(i), {8'h00, u_mem.cart[1 + i]});
    cmp("cart header", {8'h00, DEF_MODEL_ID}, {8'h00, u_mem.cart[0]});
    cw = u_mem.cartWrites;
    regWrite(REG_SRC, 16'h0001);
    regWrite(REG_CTRL, 16'h0080);
    pulseScan();
    waitBit(REG_CTRL, 7, 1'b0);
    cmp("save skips cart", 16'(cw), 16'(u_mem.cartWrites));
    $display("test cartridge copy done");
    for (i = 0; i < 16; i++)
    begin
      u_mem.ram[i] = 8'h00;
      u_mem.ee[i] = 8'h00;
    end
    doReset();
    for (i = 0; i < 16; i++)
    begin
      cmp("restore ram", 16'h00C0 + 16'(i), {8'h00, u_mem.ram[i]});
      cmp("restore ee", 16'h00C0 + 16'(i), {8'h00, u_mem.ee[i]});
    end
    regRead(REG_STAT, rd); cmp("restore status", 16'h0004, rd);
    $display("test restore done");
    for (s = 0; s < 2; s++)
    begin
      u_mem.cart[0] = (s == 0) ? BLANK_BYTE : 8'h33;
      u_mem.ee[0] = 8'h99;
      doReset();
      regRead(REG_STAT, rd); cmp("bad cart status", 16'h0024, rd);
      cmp("no restore", 16'h0099, {8'h00, u_mem.ee[0]});
    end
    $display("test bad cartridge done");
    wrap_up();
  end
endmodule : vms_eeprom_save_test
